// File: dv/srd_drive_core_tb.sv
// Self-checking bench of the rectifier drive timing core
`timescale 1ns/1ps
module srd_drive_core_tb;
  import srd_pkg::*;
  localparam int INIT_N = 100;
  localparam int ENTER_N = 16000;
  localparam int EXIT_N = 8000;

  // ***********
  // Stimulus
  // ***********
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic supply_above_start = 1'b0;
  logic supply_above_stop = 1'b0;
  logic primary_sense_input;
  logic output_sense_input = 1'b1;
  logic [VW-1:0] primary_level = 10'h0c8;
  logic [VW-1:0] output_level = 10'h0c8;
  logic [TW-1:0] blank_time_set_pin = 24'h000014;
  logic [TW-1:0] deadtime_cycles = 24'h000032;
  logic gate_drive_output;
  srd_status_t status;
  logic run = 1'b1;
  logic [15:0] per_len = 16'h00c8;
  logic [15:0] hi_len = 16'h0028;
  logic start_evt;
  logic fall_evt;
  int cyc = 0;
  int last_fall = 0;
  int mismatches = 0;
  int tests_run = 0;

  always #2.5 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (fall_evt) begin
      last_fall <= cyc;
    end
  end

  srd_drive_core #(
    .INIT_CYCLES(INIT_N),
    .STBY_ENTER_CYCLES(ENTER_N),
    .STBY_EXIT_CYCLES(EXIT_N)
  ) u_srd_drive_core (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .supply_above_start(supply_above_start),
    .supply_above_stop(supply_above_stop),
    .primary_sense_input(primary_sense_input),
    .output_sense_input(output_sense_input),
    .primary_level(primary_level),
    .output_level(output_level),
    .blank_time_set_pin(blank_time_set_pin),
    .deadtime_cycles(deadtime_cycles),
    .gate_drive_output(gate_drive_output),
    .status(status)
  );

  srd_stage_model u_srd_stage_model (
    .ref_clk(ref_clk),
    .run(run),
    .per_len(per_len),
    .hi_len(hi_len),
    .primary_sense_input(primary_sense_input),
    .start_evt(start_evt),
    .fall_evt(fall_evt)
  );

  // ***********
  // Helpers
  // ***********
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic settle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : settle

  // Returns -1 when the gate does not reach the level within lim cycles
  task automatic wait_gate(input logic lvl, input int lim, output int at);
    int n;
    n = 0;
    while (gate_drive_output !== lvl && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
    at = (n < lim) ? cyc : -1;
  endtask : wait_gate

  task automatic wait_start;
    do @(negedge ref_clk); while (start_evt !== 1'b1);
  endtask : wait_start

  task automatic one_period(input logic [15:0] len);
    wait_start();
    per_len = len;
    wait_start();
    per_len = 16'h00c8;
  endtask : one_period

  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  // ***********
  // Scenarios
  // ***********
  task automatic startup;
    int t0;
    int t;
    settle(6);
    reset_n = 1'b1;
    settle(50);
    check("status without supply", status, 4'h0);
    supply_above_stop = 1'b1;
    supply_above_start = 1'b1;
    t0 = cyc;
    wait_gate(1'b1, INIT_N + 7000, t);
    check("first drive late enough", (t - t0) >= INIT_N + 4600, 1'b1);
    check("first drive not stuck", (t - t0) <= INIT_N + 6200, 1'b1);
    check("running at first drive", status.running, 1'b1);
  endtask : startup

  // Output level picks which limit ends the on time
  task automatic on_time(input logic [VW-1:0] lvl, input int lo, input int hi, input int gap);
    int r1;
    int f1;
    int r2;
    output_level = lvl;
    settle(2000);
    wait_gate(1'b0, 1000, f1);
    wait_gate(1'b1, 1000, r1);
    check("turn-on delay", (r1 - last_fall) <= 8, 1'b1);
    check("qualified after pulse", status.qualified, 1'b1);
    wait_gate(1'b0, 1000, f1);
    check("on time", (f1 - r1) >= lo && (f1 - r1) <= hi, 1'b1);
    wait_gate(1'b1, 1000, r2);
    check("turn-on spacing", r2 - r1, gap);
  endtask : on_time

  // Short pulse, output sense off, level just under 85 percent
  task automatic blocked(input int mode);
    int t;
    if (mode == 0) hi_len = 16'h000f;
    if (mode == 1) output_sense_input = 1'b0;
    if (mode == 2) primary_level = 10'h0a9;
    settle(1000);
    wait_gate(1'b1, 1000, t);
    check("drive while blocked", t, -1);
    if (mode == 0) check("qualified on short pulse", status.qualified, 1'b0);
    hi_len = 16'h0028;
    output_sense_input = 1'b1;
    primary_level = 10'h0c8;
    settle(3000);
  endtask : blocked

  task automatic fault_case;
    one_period(16'h012c);
    settle(320);
    check("fault at exact ratio", status.ccm_fault, 1'b0);
    settle(1000);
    one_period(16'h0190);
    settle(420);
    check("fault on growth", status.ccm_fault, 1'b1);
    check("drive under fault", gate_drive_output, 1'b0);
    settle(300);
    check("fault held", status.ccm_fault, 1'b1);
    settle(500);
    check("fault cleared", status.ccm_fault, 1'b0);
  endtask : fault_case

  task automatic standby_case;
    int n;
    run = 1'b0;
    n = 0;
    while (status.standby !== 1'b1 && n < 2 * ENTER_N + 200) begin
      @(negedge ref_clk);
      n++;
    end
    check("standby entry", n < 2 * ENTER_N + 200, 1'b1);
    check("drive in standby", gate_drive_output, 1'b0);
    run = 1'b1;
    n = 0;
    while (status.standby !== 1'b0 && n < 2 * EXIT_N + 200) begin
      @(negedge ref_clk);
      n++;
    end
    check("standby exit in time", n < 2 * EXIT_N + 200, 1'b1);
    check("standby exit needs cycles", n >= 31 * 200, 1'b1);
  endtask : standby_case

  task automatic uvlo_case;
    settle(3000);
    // Supply below the stop level is below the start level as well
    supply_above_start = 1'b0;
    supply_above_stop = 1'b0;
    settle(200);
    check("gate in lockout", gate_drive_output, 1'b0);
    check("status in lockout", status, 4'h0);
  endtask : uvlo_case

  // ***********
  // Sequence
  // ***********
  initial begin
    #(98000 * 5);
    mismatches++;
    end_sim();
  end

  initial begin
    startup();
    on_time(10'h0c8, 70, 72, 600);
    on_time(10'h032, 112, 126, 800);
    on_time(10'h014, 146, 154, 800);
    output_level = 10'h0c8;
    for (int m = 0; m < 3; m++) begin
      blocked(m);
    end
    fault_case();
    standby_case();
    uvlo_case();
    end_sim();
  end
endmodule : srd_drive_core_tb

// File: dv/srd_stage_model.sv
// Flyback power stage model that shapes the primary sense pulses
`timescale 1ns/1ps
module srd_stage_model (
  // Clock
  input wire logic ref_clk,
  // Pulse shape
  input wire logic run,
  input wire logic [15:0] per_len,
  input wire logic [15:0] hi_len,
  // Sensed stage
  output logic primary_sense_input,
  output logic start_evt,
  output logic fall_evt
);
  // ************
  // Pulse engine
  // ************
  logic [15:0] cnt_q = 16'h0;
  logic [15:0] per_q = 16'h00c8;
  logic [15:0] hi_q = 16'h0028;
  logic pri_q = 1'b0;
  logic start_q = 1'b0;
  logic fall_q = 1'b0;

  assign primary_sense_input = pri_q;
  assign start_evt = start_q;
  assign fall_evt = fall_q;

  // Shape is latched per period so a change never cuts a pulse short
  always @(negedge ref_clk) begin
    start_q <= 1'b0;
    fall_q <= 1'b0;
    if (cnt_q == 16'h0) begin
      if (run) begin
        per_q <= per_len;
        hi_q <= hi_len;
        pri_q <= 1'b1;
        start_q <= 1'b1;
        cnt_q <= 16'h1;
      end
    end else begin
      if (cnt_q == hi_q) begin
        pri_q <= 1'b0;
        fall_q <= 1'b1;
      end
      cnt_q <= (cnt_q == per_q - 16'h1) ? 16'h0 : cnt_q + 16'h1;
    end
  end
endmodule : srd_stage_model

// File: hdl/srd_drive_core.sv
// Rectifier gate drive timing core with startup, ramps and standby
//
// How it works
// [RULE1] Under-voltage lockout holds logic in reset
// [RULE2] Drive needs qualified pulse and output enable
// [RULE3] Device initialization of 150 us first
// [RULE4] Then 20 us logic init enables blanking
// [RULE5] Four switching cycles warm dead-time logic
// [RULE6] On time capped by previous-period dead time
// [RULE7] Unstable periods disable drive with fault
// [RULE8] Fault at 150 percent growth, four clear
// [RULE9] Low average frequency enters standby, exits later
// [RULE10] Too few cycles in 12.8 ms enters standby
// [RULE11] Enough cycles within 2.56 ms exits standby
// [RULE12] Pulse longer than blanking qualifies conduction
// [RULE13] Ramps start at rising edge, own rates
// [RULE14] Primary ramp holds peak after falling edge
// [RULE15] Drive on at falling edge, off at crossing
// [RULE16] Ramps cleared on each qualifying rising edge
// [RULE17] Sample 100 ns window after blanking ends
// [RULE18] Dynamic threshold is 85 percent of sample
// [RULE19] Drive stays on at least 350 ns
// [RULE20] Off-hold timer blocks turn-on after fall
// [RULE21] Off-hold lasts 2.5 us
// [RULE22] Blanking length set from external input
// [RULE23] All intervals are clock counters
`timescale 1ns/1ps
module srd_drive_core #(
  parameter int unsigned INIT_CYCLES = srd_pkg::INIT_CYC,
  parameter int unsigned STBY_ENTER_CYCLES = srd_pkg::STBY_ENTER_CYC,
  parameter int unsigned STBY_EXIT_CYCLES = srd_pkg::STBY_EXIT_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Sensed inputs, asynchronous
  input wire logic supply_above_start,
  input wire logic supply_above_stop,
  input wire logic primary_sense_input,
  input wire logic output_sense_input,
  input wire logic [srd_pkg::VW-1:0] primary_level,
  input wire logic [srd_pkg::VW-1:0] output_level,
  // Configuration
  input wire logic [srd_pkg::TW-1:0] blank_time_set_pin,
  input wire logic [srd_pkg::TW-1:0] deadtime_cycles,
  // Outputs
  output logic gate_drive_output,
  output srd_pkg::srd_status_t status
);
  import srd_pkg::*;

  // ******************************************
  // Input synchronisers
  // ******************************************
  logic [1:0] s_start_q, s_stop_q, s_pri_q, s_out_q;
  logic [VW-1:0] lvl_p1_q, lvl_p2_q, lvl_o1_q, lvl_o2_q;
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      s_start_q <= '0;
      s_stop_q <= '0;
      s_pri_q <= '0;
      s_out_q <= '0;
      lvl_p1_q <= '0;
      lvl_p2_q <= '0;
      lvl_o1_q <= '0;
      lvl_o2_q <= '0;
    end else begin
      s_start_q <= {s_start_q[0], supply_above_start};
      s_stop_q <= {s_stop_q[0], supply_above_stop};
      s_pri_q <= {s_pri_q[0], primary_sense_input};
      s_out_q <= {s_out_q[0], output_sense_input};
      lvl_p1_q <= primary_level;
      lvl_p2_q <= lvl_p1_q;
      lvl_o1_q <= output_level;
      lvl_o2_q <= lvl_o1_q;
    end
  end

  srd_sense_t sense;
  assign sense = '{supply_ok: s_stop_q[1], output_en: s_out_q[1],
                   pri_level: lvl_p2_q, out_level: lvl_o2_q};

  // ******************************************
  // Under-voltage lockout
  // ******************************************
  logic uvlo_ok_q, uvlo_ok_d, run_n;
  always_comb begin
    uvlo_ok_d = uvlo_ok_q;
    // [RULE1] Start above 4.0 V, stop below 3.6 V
    if (s_start_q[1]) begin
      uvlo_ok_d = 1'b1;
    end else if (!sense.supply_ok) begin
      uvlo_ok_d = 1'b0;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      uvlo_ok_q <= 1'b0;
    end else begin
      uvlo_ok_q <= uvlo_ok_d;
    end
  end
  assign run_n = reset_n & uvlo_ok_q;

  // ******************************************
  // Pulse qualification and threshold
  // ******************************************
  logic [VW-1:0] thr_q, thr_d;
  logic above, above_q, rise, fall;
  logic [TW-1:0] blk_q, blk_d, spl_q, spl_d;
  logic qual_q, qual_d, blk_en;
  logic [VW-1:0] pk_q, pk_d;
  function automatic logic [VW-1:0] pct85(input logic [VW-1:0] v);
    logic [VW+7:0] p;
    p = (VW+8)'(v) * (VW+8)'(THRESH_PCT);
    return VW'(p / (VW+8)'(100));
  endfunction
  assign above = s_pri_q[1] && (sense.pri_level >= thr_q);
  assign rise = above && !above_q;
  assign fall = !s_pri_q[1] && above_q;

  always_comb begin
    blk_d = blk_q;
    spl_d = spl_q;
    qual_d = qual_q;
    thr_d = thr_q;
    pk_d = pk_q;
    // [RULE16] Qualifying rise restarts blanking
    if (rise && blk_en) begin
      // [RULE22] Blanking loaded from set input
      blk_d = blank_time_set_pin;
      qual_d = 1'b0;
      spl_d = '0;
      pk_d = '0;
    end else if (blk_q != '0) begin
      // [RULE23] Blanking counter
      blk_d = blk_q - 1'b1;
      if (!above) begin
        blk_d = '0;
      end else if (blk_q == TW'(1)) begin
        // [RULE12] Qualified after full blanking
        qual_d = 1'b1;
        // [RULE17] Open sampling window
        spl_d = TW'(SAMPLE_CYC);
      end
    end
    if (spl_q != '0) begin
      spl_d = spl_q - 1'b1;
      if (sense.pri_level > pk_q) begin
        pk_d = sense.pri_level;
      end
      if (spl_q == TW'(1)) begin
        // [RULE18] Threshold from captured sample
        thr_d = pct85((sense.pri_level > pk_q) ? sense.pri_level : pk_q);
      end
    end
    if (fall && !qual_d) begin
      blk_d = '0;
    end
  end

  // ******************************************
  // Startup sequencing
  // ******************************************
  srd_phase_t ph_q, ph_d;
  logic [TW-1:0] st_q, st_d;
  logic [2:0] warm_q, warm_d;
  assign blk_en = (ph_q != SRD_DEV_INIT) && (ph_q != SRD_LOGIC_INIT);
  always_comb begin
    ph_d = ph_q;
    st_d = st_q;
    warm_d = warm_q;
    case (ph_q)
      SRD_DEV_INIT: begin
        // [RULE3] Device initialization time
        st_d = st_q + 1'b1;
        if (st_q == TW'(INIT_CYCLES - 1)) begin
          st_d = '0;
          ph_d = SRD_LOGIC_INIT;
        end
      end
      SRD_LOGIC_INIT: begin
        // [RULE4] Logic init, then blanking enabled
        st_d = st_q + 1'b1;
        if (st_q == TW'(LOGIC_INIT_CYC - 1)) begin
          st_d = '0;
          ph_d = SRD_WAIT_EN;
        end
      end
      SRD_WAIT_EN: begin
        if (qual_q && sense.output_en) begin
          ph_d = SRD_WARMUP;
        end
      end
      SRD_WARMUP: begin
        // [RULE5] Four cycles before drive allowed
        if (rise) begin
          warm_d = warm_q + 1'b1;
          if (warm_q == 3'(WARMUP_N - 1)) begin
            ph_d = SRD_RUN;
          end
        end
      end
      SRD_RUN: ph_d = SRD_RUN;
      default: ph_d = SRD_DEV_INIT;
    endcase
  end

  // ******************************************
  // Period monitor and standby
  // ******************************************
  logic [TW-1:0] prev_period;
  logic period_valid, ccm_fault;
  srd_period_mon u_period (
    .ref_clk(ref_clk),
    .reset_n(run_n),
    .cycle_start(rise),
    .prev_period(prev_period),
    .period_valid(period_valid),
    .fault(ccm_fault)
  );

  logic stby_q, stby_d;
  logic [TW-1:0] win_q, win_d;
  logic [7:0] ncyc_q, ncyc_d;
  always_comb begin
    stby_d = stby_q;
    win_d = win_q + 1'b1;
    ncyc_d = ncyc_q;
    if (rise && ncyc_q != 8'hff) begin
      ncyc_d = ncyc_q + 1'b1;
    end
    // [RULE9] Frequency tracking steers standby
    if (!stby_q) begin
      if (win_q == TW'(STBY_ENTER_CYCLES - 1)) begin
        // [RULE10] Too few cycles enters standby
        stby_d = (ncyc_d < 8'(STBY_ENTER_N));
        win_d = '0;
        ncyc_d = '0;
      end
    end else begin
      // [RULE11] Exit as soon as count reached
      if (ncyc_d >= 8'(STBY_EXIT_N)) begin
        stby_d = 1'b0;
        win_d = '0;
        ncyc_d = '0;
      end else if (win_q == TW'(STBY_EXIT_CYCLES - 1)) begin
        win_d = '0;
        ncyc_d = '0;
      end
    end
  end

  // ******************************************
  // Ramps and gate drive
  // ******************************************
  logic [RW-1:0] rp_q, rp_d, rs_q, rs_d;
  logic pri_hold_q, pri_hold_d;
  logic drv_q, drv_d;
  logic [TW-1:0] on_q, on_d, off_q, off_d, dt_lim;
  logic allow;
  assign dt_lim = (prev_period > deadtime_cycles) ? prev_period - deadtime_cycles : TW'(1);
  // [RULE2] Drive gates: qualification, output sense, run
  assign allow = qual_q && sense.output_en && ph_q == SRD_RUN && !stby_q && !ccm_fault;

  always_comb begin
    rp_d = rp_q;
    rs_d = rs_q;
    pri_hold_d = pri_hold_q;
    drv_d = drv_q;
    on_d = (on_q != '0) ? on_q + 1'b1 : on_q;
    off_d = (off_q != '0) ? off_q - 1'b1 : off_q;
    if (rise) begin
      // [RULE16] Ramps cleared on rise
      rp_d = '0;
      rs_d = '0;
      pri_hold_d = 1'b0;
    end else begin
      // [RULE13] Ramps rise at their own rates
      if (!pri_hold_q) begin
        rp_d = rp_q + RW'(sense.pri_level);
      end
      rs_d = rs_q + RW'(sense.out_level);
      // [RULE14] Hold primary peak after fall
      if (fall) begin
        pri_hold_d = 1'b1;
      end
    end
    if (!drv_q) begin
      // [RULE15] Turn on at falling edge
      // [RULE20] Blocked while off-hold runs
      if (fall && allow && off_q == '0) begin
        drv_d = 1'b1;
        on_d = TW'(1);
      end
    end else begin
      // [RULE19] Minimum on time first
      if (on_q >= TW'(MIN_ON_CYC)) begin
        // [RULE15] Off when secondary ramp meets held level
        // [RULE6] Dead-time cap from previous period
        // [RULE7] Fault or standby drops drive
        if (rs_q >= rp_q || (period_valid && on_q >= dt_lim) || ccm_fault || stby_q ||
            rise) begin
          drv_d = 1'b0;
          on_d = '0;
          // [RULE21] Off-hold 2.5 us
          off_d = TW'(OFF_HOLD_CYC);
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!run_n) begin
      above_q <= 1'b0;
      thr_q <= '0;
      blk_q <= '0;
      spl_q <= '0;
      qual_q <= 1'b0;
      pk_q <= '0;
      ph_q <= SRD_DEV_INIT;
      st_q <= '0;
      warm_q <= '0;
      stby_q <= 1'b0;
      win_q <= '0;
      ncyc_q <= '0;
      rp_q <= '0;
      rs_q <= '0;
      pri_hold_q <= 1'b0;
      drv_q <= 1'b0;
      on_q <= '0;
      off_q <= '0;
    end else begin
      above_q <= above;
      thr_q <= thr_d;
      blk_q <= blk_d;
      spl_q <= spl_d;
      qual_q <= qual_d;
      pk_q <= pk_d;
      ph_q <= ph_d;
      st_q <= st_d;
      warm_q <= warm_d;
      stby_q <= stby_d;
      win_q <= win_d;
      ncyc_q <= ncyc_d;
      rp_q <= rp_d;
      rs_q <= rs_d;
      pri_hold_q <= pri_hold_d;
      drv_q <= drv_d;
      on_q <= on_d;
      off_q <= off_d;
    end
  end

  assign gate_drive_output = drv_q;
  assign status = '{standby: stby_q, ccm_fault: ccm_fault, running: ph_q == SRD_RUN,
                    qualified: qual_q};

  // ******************************************
  // Assertions
  // ******************************************
  property p_drive_needs_run;
    @(posedge ref_clk) disable iff (!run_n) $rose(drv_q) |-> $past(allow);
  endproperty
  a_drive_needs_run: assert property (p_drive_needs_run) // RULE2
    else $error("drive rose without enable conditions");

  property p_min_on;
    @(posedge ref_clk) disable iff (!run_n) (drv_q && on_q < TW'(MIN_ON_CYC)) |=> drv_q;
  endproperty
  a_min_on: assert property (p_min_on) // RULE19
    else $error("drive shorter than minimum on time");

  property p_off_hold;
    @(posedge ref_clk) disable iff (!run_n) (off_q != '0) |=> !drv_q;
  endproperty
  a_off_hold: assert property (p_off_hold) // RULE20
    else $error("drive back on during off hold");

  property p_fault_off;
    @(posedge ref_clk) disable iff (!run_n)
      (ccm_fault && drv_q && on_q >= TW'(MIN_ON_CYC)) |=> !drv_q;
  endproperty
  a_fault_off: assert property (p_fault_off) // RULE7
    else $error("drive kept on under fault");

  property p_on_at_fall;
    @(posedge ref_clk) disable iff (!run_n) $rose(drv_q) |-> $past(fall);
  endproperty
  a_on_at_fall: assert property (p_on_at_fall) // RULE15
    else $error("drive rose away from falling edge");

  property p_ramp_clear;
    @(posedge ref_clk) disable iff (!run_n) rise |=> (rp_q == '0 && rs_q == '0);
  endproperty
  a_ramp_clear: assert property (p_ramp_clear) // RULE16
    else $error("ramps not cleared on rise");

  property p_hold_peak;
    @(posedge ref_clk) disable iff (!run_n) (pri_hold_q && !rise) |=> $stable(rp_q);
  endproperty
  a_hold_peak: assert property (p_hold_peak) // RULE14
    else $error("primary ramp moved while held");

  property p_no_drive_standby;
    @(posedge ref_clk) disable iff (!run_n) (stby_q && !drv_q) |=> !drv_q;
  endproperty
  a_no_drive_standby: assert property (p_no_drive_standby) // RULE10
    else $error("drive rose in standby");

  property p_no_drive_early;
    @(posedge ref_clk) disable iff (!run_n) (ph_q != SRD_RUN) |-> !drv_q;
  endproperty
  a_no_drive_early: assert property (p_no_drive_early) // RULE5
    else $error("drive before startup completed");

  c_drive_pulse: cover property (@(posedge ref_clk) disable iff (!run_n) $fell(drv_q));
  c_standby: cover property (@(posedge ref_clk) disable iff (!run_n) $rose(stby_q));
  c_fault: cover property (@(posedge ref_clk) disable iff (!run_n) $rose(ccm_fault));

endmodule : srd_drive_core

// File: hdl/srd_period_mon.sv
// Switching period tracker: dead-time limit and unstable-period fault
`timescale 1ns/1ps
module srd_period_mon (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Cycle events
  input wire logic cycle_start,
  // Results
  output logic [srd_pkg::TW-1:0] prev_period,
  output logic period_valid,
  output logic fault
);
  import srd_pkg::*;

  logic [TW-1:0] cnt_q, cnt_d;
  logic [TW-1:0] prev_q, prev_d;
  logic valid_q, valid_d;
  logic fault_q, fault_d;
  logic [2:0] good_q, good_d;
  logic [TW+8:0] lim;
  logic [TW+8:0] cur;

  always_comb begin
    cnt_d = cnt_q + 1'b1;
    prev_d = prev_q;
    valid_d = valid_q;
    fault_d = fault_q;
    good_d = good_q;
    lim = (TW+9)'(prev_q) * (TW+9)'(GROWTH_PCT);
    cur = (TW+9)'(cnt_q) * (TW+9)'(100);
    if (cycle_start) begin
      // Start edge counts as the first clock, so the count equals the period
      cnt_d = TW'(1);
      prev_d = cnt_q;
      valid_d = 1'b1;
      if (valid_q) begin
        // [RULE8] Growth fault, four good clear
        if (cur > lim) begin
          fault_d = 1'b1;
          good_d = '0;
        end else if (fault_q) begin
          if (good_q == 3'(FAULT_CLR_N - 1)) begin
            fault_d = 1'b0;
            good_d = '0;
          end else begin
            good_d = good_q + 1'b1;
          end
        end
      end
    end else if (cnt_q == '1) begin
      cnt_d = cnt_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cnt_q <= '0;
      prev_q <= '0;
      valid_q <= 1'b0;
      fault_q <= 1'b0;
      good_q <= '0;
    end else begin
      cnt_q <= cnt_d;
      prev_q <= prev_d;
      valid_q <= valid_d;
      fault_q <= fault_d;
      good_q <= good_d;
    end
  end

  assign prev_period = prev_q;
  assign period_valid = valid_q;
  // [RULE7] Unstable periods raise fault
  assign fault = fault_q;

  property p_fault_clear_needs_cycle;
    @(posedge ref_clk) disable iff (!reset_n)
      $fell(fault_q) |-> $past(cycle_start);
  endproperty
  a_fault_clear_needs_cycle: assert property (p_fault_clear_needs_cycle) // RULE8
    else $error("fault cleared without a cycle");

endmodule : srd_period_mon

// File: hdl/srd_pkg.sv
// Shared types and timing constants of the rectifier drive timing core
package srd_pkg;

  // Clock rate and period
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned CLK_PS = 5000;

  // Printed times in their own units
  localparam int unsigned INIT_MIN_US = 150;
  localparam int unsigned INIT_MAX_US = 250;
  localparam int unsigned LOGIC_INIT_US = 20;
  localparam int unsigned SAMPLE_NS = 100;
  localparam int unsigned MIN_ON_NS = 350;
  localparam int unsigned OFF_HOLD_PS = 2500000;
  localparam int unsigned STBY_ENTER_US = 12800;
  localparam int unsigned STBY_EXIT_US = 2560;
  localparam int unsigned BLANK_DEF_NS = 1000;

  // Cycle counts; the initialization figure uses the least time, and the sample, minimum on and off-hold figures round up
  localparam int unsigned INIT_CYC = (INIT_MIN_US * CLK_MHZ);
  localparam int unsigned LOGIC_INIT_CYC = LOGIC_INIT_US * CLK_MHZ;
  localparam int unsigned SAMPLE_CYC = (SAMPLE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned MIN_ON_CYC = (MIN_ON_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned OFF_HOLD_CYC = (OFF_HOLD_PS + CLK_PS - 1) / CLK_PS;
  localparam int unsigned STBY_ENTER_CYC = STBY_ENTER_US * CLK_MHZ;
  localparam int unsigned STBY_EXIT_CYC = STBY_EXIT_US * CLK_MHZ;
  localparam int unsigned BLANK_DEF_CYC = (BLANK_DEF_NS * 1000) / CLK_PS;

  // Standby cycle thresholds and fault figures
  localparam int unsigned STBY_ENTER_N = 64;
  localparam int unsigned STBY_EXIT_N = 32;
  localparam int unsigned GROWTH_PCT = 150;
  localparam int unsigned THRESH_PCT = 85;
  localparam int unsigned FAULT_CLR_N = 4;
  localparam int unsigned WARMUP_N = 4;

  // Widths
  localparam int unsigned TW = 24;
  localparam int unsigned VW = 10;
  localparam int unsigned RW = 32;

  // Startup phases
  typedef enum logic [2:0] {
    SRD_DEV_INIT,
    SRD_LOGIC_INIT,
    SRD_WAIT_EN,
    SRD_WARMUP,
    SRD_RUN
  } srd_phase_t;

  // Sampled comparator and level inputs
  typedef struct packed {
    logic supply_ok;
    logic output_en;
    logic [VW-1:0] pri_level;
    logic [VW-1:0] out_level;
  } srd_sense_t;

  // Visible status
  typedef struct packed {
    logic standby;
    logic ccm_fault;
    logic running;
    logic qualified;
  } srd_status_t;

endpackage : srd_pkg
